// *** acrp_defines.svh ***
`ifndef ACRP_DEFINES_SVH
`define ACRP_DEFINES_SVH

// ****************************************************
// register indices (byte address is four times these)
// ****************************************************
`define ACRP_IDX_LATCH   7'h62
`define ACRP_IDX_CNT_HI  7'h66
`define ACRP_IDX_CNT_LO  7'h67
`define ACRP_IDX_STATUS  7'h68
`define ACRP_IDX_CTRL1   7'h69
`define ACRP_IDX_CTRL2   7'h6A

// ****************************************************
// reset values and field positions
// ****************************************************
`define ACRP_STATUS_RST  8'h04
`define ACRP_CTRL1_RST   6'h01
`define ACRP_CTRL2_RST   5'h00
`define ACRP_ST_OVR      0
`define ACRP_ST_LCDCH    1
`define ACRP_ST_LCD      2
`define ACRP_ST_RMS      3
`define ACRP_ST_CDS      4
`define ACRP_C1_COSET    0
`define ACRP_C1_CORR     1
`define ACRP_C1_DESCR    2
`define ACRP_C1_PASS     3
`define ACRP_C1_IDLE     4
`define ACRP_C1_UNAS     5
`define ACRP_C2_LOOP     0
`define ACRP_C2_GAPPED   1
`define ACRP_C2_OVRM     3
`define ACRP_C2_LCDM     4

// ****************************************************
// cell and timing constants
// ****************************************************
`define ACRP_COSET       8'h55
`define ACRP_HEC_POLY    8'h07
`define ACRP_IDLE_HDR    32'h0000_0001
`define ACRP_HDR_BYTES   4
`define ACRP_CELL_LAST   6'h34
`define ACRP_STORED      52
`define ACRP_SYSCLK_DIV  8
`define ACRP_DESCR_LEN   43
`endif

// *** acrp_pkg.sv ***
package acrp_pkg;
   // delineation states, one-hot
   typedef enum logic [2:0] {
      ACRP_HUNT    = 3'b001,
      ACRP_PRESYNC = 3'b010,
      ACRP_SYNC    = 3'b100
   } acrp_delin_t;

   // verdict on one five-byte header
   typedef struct packed {
      logic        ok;
      logic        fixable;
      logic [31:0] hdr;
   } acrp_hec_res_t;
endpackage

// *** acrp_hec_check.sv ***
`timescale 1ns/1ps
`include "acrp_defines.svh"
module acrp_hec_check (
   input  wire logic [39:0]          hdr_i,      // four header bytes then check byte
   input  wire logic                 coset_en_i, // remove coset before check
   output acrp_pkg::acrp_hec_res_t   res_o       // verdict and repaired header
);
   // ****************************************************
   // crc-8 over the header, msb first
   // ****************************************************
   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c  = {c[6:0], 1'b0};
         if (fb) begin
            c = c ^ `ACRP_HEC_POLY;
         end
      end
      return c;
   endfunction

   wire logic [7:0] coset_w = coset_en_i ? `ACRP_COSET : 8'h00;
   wire logic [7:0] syn_w   = crc8(hdr_i[39:8]) ^ hdr_i[7:0] ^ coset_w;

   // search the 40 single-bit error syndromes; linear code so xor works
   always_comb begin
      logic [39:0] e;
      e = 40'h00_0000_0000;
      res_o.ok      = (syn_w == 8'h00);
      res_o.fixable = 1'b0;
      res_o.hdr     = hdr_i[39:8];
      for (int i = 0; i < 40; i++) begin
         e = 40'h00_0000_0001 << i;
         if (syn_w != 8'h00 && (crc8(e[39:8]) ^ e[7:0]) == syn_w) begin
            res_o.fixable = 1'b1;
            res_o.hdr     = hdr_i[39:8] ^ e[39:8];
         end
      end
   end
endmodule

// *** acrp_top.sv ***
`timescale 1ns/1ps
`include "acrp_defines.svh"
module acrp_top #(
   parameter int FIFO_CELLS = 4,   // cells held before overrun
   parameter int ALPHA      = 7,   // bad headers in sync to lose it
   parameter int DELTA      = 6    // good headers in presync to gain sync
) (
   input  wire logic        CLOCK_I,            // 50 MHz system clock
   input  wire logic        RST_B_I,            // async reset, active low
   input  wire logic        PSEL_I,             // apb select
   input  wire logic        PENABLE_I,          // apb access phase
   input  wire logic        PWRITE_I,           // apb write
   input  wire logic [8:0]  PADDR_I,            // apb byte address
   input  wire logic [31:0] PWDATA_I,           // apb write data
   output logic      [31:0] PRDATA_O,           // apb read data
   output logic             PREADY_O,           // apb ready
   output logic             PSLVERR_O,          // unmapped address
   input  wire logic        PHY_CLK_I,          // line clock from framer
   input  wire logic        PHY_DATA_I,         // line data from framer
   input  wire logic        PHY_FRAME_I,        // frame pulse from framer
   input  wire logic        TX_CLK_I,           // transmit section clock
   input  wire logic        TX_DATA_I,          // transmit section data
   input  wire logic        TX_FRAME_I,         // transmit section frame pulse
   input  wire logic        LOOP_SYSCLK_SEL_I,  // loopback_sysclk_select
   input  wire logic        ATM_RD_I,           // atm layer takes one byte
   output logic             ATM_VALID_O,        // a byte is available
   output logic             ATM_SOC_O,          // byte is first of a cell
   output logic      [7:0]  ATM_DATA_O,         // cell byte
   output logic             IRQ_O               // external interrupt
);
   // elaboration check: two-bit slot index and four-bit run counters
   if (FIFO_CELLS < 2 || FIFO_CELLS > 4 || ALPHA < 1 || ALPHA > 15 ||
       DELTA < 1 || DELTA > 15) begin
      $error("acrp_top: parameter out of range");
   end

   // ****************************************************
   // storage index helper
   // ****************************************************
   function automatic logic [7:0] slot_idx(input logic [1:0] slot, input logic [5:0] pos);
      return 8'(slot * `ACRP_STORED) + 8'(pos);
   endfunction

   // descramble one byte through the 43-stage self-synchronising register
   function automatic logic [50:0] descr(input logic [42:0] s, input logic [7:0] b);
      logic [42:0] st;
      logic [7:0]  o;
      st = s;
      o  = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         o[i] = b[i] ^ st[`ACRP_DESCR_LEN-1];
         st   = {st[41:0], b[i]};
      end
      return {st, o};
   endfunction

   // ****************************************************
   // registers and state
   // ****************************************************
   logic [5:0]  ctrl1_r;
   logic [4:0]  ctrl2_r;
   logic [15:0] cnt_r, latch_r;
   logic        ovr_flag_r, lcd_flag_r, lcd_r, rmode_r, pready_r;
   logic [7:0]  prdata_r;
   acrp_pkg::acrp_delin_t state_r, state_nxt;
   logic [3:0]  good_r, bad_r;
   logic [5:0]  pos_r;
   logic [2:0]  bit_cnt_r, div_r;
   logic [6:0]  sh_r;
   logic        clk_q_r;
   logic [39:0] win_r;
   logic [42:0] scr_r;
   logic        wr_act_r;
   logic [1:0]  wr_slot_r, rd_slot_r;
   logic [2:0]  fifo_cnt_r;
   logic [5:0]  rd_pos_r;
   logic [7:0]  mem_r [0:4*`ACRP_STORED-1];

   // ****************************************************
   // line input selection and bit recovery
   // ****************************************************
   wire logic loop_w   = ctrl2_r[`ACRP_C2_LOOP];
   wire logic sel_clk  = loop_w ? TX_CLK_I : PHY_CLK_I;
   wire logic sel_dat  = loop_w ? TX_DATA_I : PHY_DATA_I;
   wire logic sel_frm  = loop_w ? TX_FRAME_I : PHY_FRAME_I;
   wire logic div_tick = (div_r == 3'(`ACRP_SYSCLK_DIV - 1));
   wire logic clk_rise = sel_clk & ~clk_q_r;
   // system clock divided by 8 stands in for the transmit clock
   wire logic bit_stb  = (loop_w & LOOP_SYSCLK_SEL_I) ? div_tick : clk_rise;
   // frame pulse realigns bytes only in clock+data+frame mode
   wire logic frm_al   = ~ctrl2_r[`ACRP_C2_GAPPED] & sel_frm;
   wire logic [2:0] eff_cnt = frm_al ? 3'd0 : bit_cnt_r;
   wire logic byte_stb = bit_stb & (eff_cnt == 3'd7);
   wire logic [7:0] byte_w = {sh_r, sel_dat};

   // divider runs free; line clock sampled as a plain input
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         div_r     <= 3'd0;
         clk_q_r   <= 1'b0;
         bit_cnt_r <= 3'd0;
         sh_r      <= 7'h00;
      end else begin
         div_r   <= div_r + 3'd1;
         clk_q_r <= sel_clk;
         if (bit_stb) begin
            bit_cnt_r <= eff_cnt + 3'd1;
            sh_r      <= byte_w[6:0];
         end
      end
   end

   // ****************************************************
   // header check and delineation
   // ****************************************************
   acrp_pkg::acrp_hec_res_t res_w;
   wire logic [39:0] win_nxt = {win_r[31:0], byte_w};
   wire logic is_hunt = (state_r == acrp_pkg::ACRP_HUNT);
   wire logic is_sync = (state_r == acrp_pkg::ACRP_SYNC);
   wire logic hdr_chk = byte_stb & (is_hunt | pos_r == 6'd4);

   acrp_hec_check u_hec (
      .hdr_i      (win_nxt),
      .coset_en_i (ctrl1_r[`ACRP_C1_COSET]),
      .res_o      (res_w)
   );

   // hunt slides byte by byte; presync and sync check once per cell
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         acrp_pkg::ACRP_HUNT: begin
            if (hdr_chk && res_w.ok) begin
               state_nxt = acrp_pkg::ACRP_PRESYNC;
            end
         end
         acrp_pkg::ACRP_PRESYNC: begin
            if (hdr_chk && !res_w.ok) begin
               state_nxt = acrp_pkg::ACRP_HUNT;
            end else if (hdr_chk && good_r == 4'(DELTA - 1)) begin
               state_nxt = acrp_pkg::ACRP_SYNC;
            end
         end
         acrp_pkg::ACRP_SYNC: begin
            if (hdr_chk && !res_w.ok && bad_r == 4'(ALPHA - 1)) begin
               state_nxt = acrp_pkg::ACRP_HUNT;
            end
         end
         default: state_nxt = acrp_pkg::ACRP_HUNT;
      endcase
   end

   wire logic lcd_nxt = (state_nxt != acrp_pkg::ACRP_SYNC);
   wire logic lcd_evt = (lcd_nxt != lcd_r);

   // ****************************************************
   // cell verdict, filters and descrambling
   // ****************************************************
   wire logic corr_en  = ctrl1_r[`ACRP_C1_CORR];
   wire logic fix_ok   = res_w.fixable & corr_en & ~rmode_r;
   wire logic good_w   = res_w.ok | fix_ok;
   wire logic [31:0] hdr_use = fix_ok ? res_w.hdr : win_nxt[39:8];
   wire logic idle_w   = good_w & (hdr_use == `ACRP_IDLE_HDR);
   wire logic unas_w   = good_w & (hdr_use == 32'h0000_0000);
   wire logic filt_w   = (idle_w & ctrl1_r[`ACRP_C1_IDLE]) |
                         (unas_w & ctrl1_r[`ACRP_C1_UNAS]);
   wire logic pass_w   = good_w | ctrl1_r[`ACRP_C1_PASS];
   wire logic accept_w = hdr_chk & is_sync & pass_w & ~filt_w;
   wire logic full_w   = (fifo_cnt_r == 3'(FIFO_CELLS));
   wire logic drop_w   = accept_w & full_w;
   wire logic pay_w    = byte_stb & ~is_hunt & pos_r > 6'd4;
   wire logic [50:0] dsc_w = descr(scr_r, byte_w);
   wire logic [7:0] pay_byte = ctrl1_r[`ACRP_C1_DESCR] ? dsc_w[7:0] : byte_w;
   wire logic commit_w = wr_act_r & pay_w & (pos_r == `ACRP_CELL_LAST);
   wire logic rd_take  = ATM_RD_I & ATM_VALID_O;
   wire logic rd_done  = rd_take & (rd_pos_r == 6'(`ACRP_STORED - 1));
   wire logic [2:0] fifo_nxt = fifo_cnt_r + {2'b00, commit_w} - {2'b00, rd_done};
   wire logic ovr_evt  = commit_w & (fifo_nxt == 3'(FIFO_CELLS));

   // delineation counters, receiver mode and cell position
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_r <= acrp_pkg::ACRP_HUNT;
         lcd_r   <= 1'b1;
         good_r  <= 4'd0;
         bad_r   <= 4'd0;
         pos_r   <= 6'd0;
         rmode_r <= 1'b0;
         win_r   <= 40'h00_0000_0000;
         scr_r   <= 43'h000_0000_0000;
      end else begin
         state_r <= state_nxt;
         lcd_r   <= lcd_nxt;
         if (byte_stb) begin
            win_r <= win_nxt;
            pos_r <= (is_hunt || pos_r == `ACRP_CELL_LAST) ? (is_hunt ? 6'd5 : 6'd0)
                                                           : pos_r + 6'd1;
         end
         if (pay_w) begin
            scr_r <= dsc_w[50:8];
         end
         if (hdr_chk) begin
            good_r <= (is_hunt || !res_w.ok) ? 4'd0 : good_r + 4'd1;
            bad_r  <= (!is_sync || res_w.ok) ? 4'd0 : bad_r + 4'd1;
         end
         // single error moves to detection; a clean header returns
         if (hdr_chk && is_sync && corr_en) begin
            rmode_r <= ~res_w.ok;
         end
      end
   end

   // ****************************************************
   // receive fifo, four cells of 52 stored bytes
   // ****************************************************
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wr_act_r   <= 1'b0;
         wr_slot_r  <= 2'd0;
         rd_slot_r  <= 2'd0;
         rd_pos_r   <= 6'd0;
         fifo_cnt_r <= 3'd0;
      end else begin
         fifo_cnt_r <= fifo_nxt;
         if (accept_w) begin
            wr_act_r <= ~full_w;
         end else if (commit_w || is_hunt) begin
            wr_act_r <= 1'b0;
         end
         if (commit_w) begin
            wr_slot_r <= 2'(wr_slot_r == 2'(FIFO_CELLS - 1) ? 2'd0 : wr_slot_r + 2'd1);
         end
         if (rd_take) begin
            rd_pos_r <= rd_done ? 6'd0 : rd_pos_r + 6'd1;
         end
         if (rd_done) begin
            rd_slot_r <= 2'(rd_slot_r == 2'(FIFO_CELLS - 1) ? 2'd0 : rd_slot_r + 2'd1);
         end
      end
   end

   // storage has no reset; contents are only read behind the count
   always_ff @(posedge CLOCK_I) begin
      if (accept_w && !full_w) begin
         for (int i = 0; i < `ACRP_HDR_BYTES; i++) begin
            mem_r[slot_idx(wr_slot_r, 6'(i))] <= hdr_use[31-8*i -: 8];
         end
      end
      if (wr_act_r && pay_w) begin
         mem_r[slot_idx(wr_slot_r, pos_r - 6'd1)] <= pay_byte;
      end
   end

   assign ATM_VALID_O = (fifo_cnt_r != 3'd0);
   assign ATM_SOC_O   = ATM_VALID_O & (rd_pos_r == 6'd0);
   assign ATM_DATA_O  = mem_r[slot_idx(rd_slot_r, rd_pos_r)];

   // ****************************************************
   // apb slave, one wait state
   // ****************************************************
   wire logic acc_w    = PSEL_I & PENABLE_I;
   wire logic done_w   = acc_w & pready_r;
   wire logic [6:0] idx_w = PADDR_I[8:2];
   wire logic hit_lat  = (idx_w == `ACRP_IDX_LATCH);
   wire logic hit_hi   = (idx_w == `ACRP_IDX_CNT_HI);
   wire logic hit_lo   = (idx_w == `ACRP_IDX_CNT_LO);
   wire logic hit_st   = (idx_w == `ACRP_IDX_STATUS);
   wire logic hit_c1   = (idx_w == `ACRP_IDX_CTRL1);
   wire logic hit_c2   = (idx_w == `ACRP_IDX_CTRL2);
   wire logic mapped_w = hit_lat | hit_hi | hit_lo | hit_st | hit_c1 | hit_c2;
   wire logic wr_done  = done_w & PWRITE_I & mapped_w;
   wire logic st_rd    = done_w & ~PWRITE_I & hit_st;
   wire logic lat_wr   = wr_done & hit_lat;
   wire logic [1:0] cds_w = is_sync ? 2'b10 : (is_hunt ? 2'b00 : 2'b01);
   wire logic [7:0] status_w = {2'b00, cds_w, rmode_r, lcd_r, lcd_flag_r, ovr_flag_r};
   wire logic [7:0] rd_mux =
      hit_hi ? latch_r[15:8] :
      hit_lo ? latch_r[7:0] :
      hit_st ? status_w :
      hit_c1 ? {2'b00, ctrl1_r} :
      hit_c2 ? {3'b000, ctrl2_r} : 8'h00;
   wire logic ovr_set  = ovr_evt & ctrl2_r[`ACRP_C2_OVRM];
   wire logic lcd_set  = lcd_evt & ctrl2_r[`ACRP_C2_LCDM];

   assign PREADY_O  = pready_r;
   assign PSLVERR_O = done_w & ~mapped_w;
   assign PRDATA_O  = {24'h00_0000, prdata_r};
   assign IRQ_O     = ovr_flag_r | lcd_flag_r;

   // read data is captured in the first access cycle
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pready_r <= 1'b0;
         prdata_r <= 8'h00;
         ctrl1_r  <= `ACRP_CTRL1_RST;
         ctrl2_r  <= `ACRP_CTRL2_RST;
      end else begin
         pready_r <= acc_w & ~pready_r;
         if (acc_w && !pready_r) begin
            prdata_r <= PWRITE_I ? 8'h00 : rd_mux;
         end
         if (wr_done && hit_c1) begin
            ctrl1_r <= PWDATA_I[5:0];
         end
         if (wr_done && hit_c2) begin
            ctrl2_r <= PWDATA_I[4:0];
         end
      end
   end

   // only flags that were actually returned are cleared; a new set wins
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ovr_flag_r <= 1'b0;
         lcd_flag_r <= 1'b0;
         cnt_r      <= 16'h0000;
         latch_r    <= 16'h0000;
      end else begin
         ovr_flag_r <= ovr_set | (ovr_flag_r & ~(st_rd & prdata_r[`ACRP_ST_OVR]));
         lcd_flag_r <= lcd_set | (lcd_flag_r & ~(st_rd & prdata_r[`ACRP_ST_LCDCH]));
         if (lat_wr) begin
            latch_r <= cnt_r;
            cnt_r   <= {15'h0000, accept_w};
         end else if (accept_w) begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);

   sequence apb_setup_s;  PSEL_I && !PENABLE_I;  endsequence
   sequence apb_wait_s;   acc_w && !PREADY_O;  endsequence

   apb_one_wait_a: assert property (apb_setup_s ##1 apb_wait_s |=> PREADY_O || !acc_w)
      else $error("apb ready not one cycle after access");
   ovr_flag_set_a: assert property (ovr_set |=> ovr_flag_r && IRQ_O)
      else $error("overrun flag not set");
   lcd_flag_set_a: assert property (lcd_evt && ctrl2_r[4] |=> lcd_flag_r)
      else $error("delineation change flag not set");
   flag_read_clr_a: assert property (st_rd && prdata_r[0] && !ovr_set |=> !ovr_flag_r)
      else $error("status read did not clear overrun flag");
   irq_drop_a: assert property ($fell(IRQ_O) |-> $past(st_rd))
      else $error("interrupt fell without status read");
   latch_copy_a: assert property (lat_wr && !accept_w |=> latch_r == $past(cnt_r) && cnt_r == 16'h0000)
      else $error("latch did not copy and clear counter");
   cnt_in_sync_a: assert property (cnt_r != $past(cnt_r) && !$past(lat_wr) |-> $past(is_sync))
      else $error("counter moved outside sync");
   full_drop_a: assert property (drop_w |=> !wr_act_r && fifo_cnt_r == $past(fifo_cnt_r) - 3'($past(rd_done)))
      else $error("cell written into full fifo");
   lcd_match_a: assert property ($rose(is_sync) |-> !lcd_r && $past(lcd_r))
      else $error("loss status did not clear on gaining sync");
   hunt_exit_a: assert property (is_hunt && hdr_chk && res_w.ok |=> state_r == acrp_pkg::ACRP_PRESYNC)
      else $error("hunt did not move to presync");
endmodule

// *** acrp_atm_model.sv ***
`timescale 1ns/1ps
// ************************************
// atm layer reader on the cell bus
// ************************************
module acrp_atm_model (
   input  wire logic       clk_i,   // system clock
   input  wire logic       en_i,    // reader willing to take bytes
   input  wire logic       valid_i, // a byte is offered
   input  wire logic [7:0] data_i,  // offered byte
   input  wire logic       soc_i,   // offered byte opens a cell
   output logic            rd_o     // pop strobe
);
   logic [7:0] q[$];
   int         n_soc;
   // pop only while offered, so an empty fifo is never read
   assign rd_o = en_i & valid_i;
   // keep every byte taken; the bench compares them afterwards
   always @(posedge clk_i) begin
      if (rd_o) begin
         q.push_back(data_i);
         if (soc_i) begin
            n_soc++;
         end
      end
   end
endmodule

// *** tb_atm_cell_receive_processor.sv ***
`timescale 1ns/1ps
module tb_atm_cell_receive_processor;
   // ************************************
   // stimulus signals and counters
   // ************************************
   logic        clk, rst_b, psel, pen, pw, phy_clk, phy_d, phy_f, en, e;
   logic        prdy, perr, rd, vld, irq, soc, tx_clk, tx_d, tx_f, lsel, lp;
   int          hp;
   logic [8:0]  pa;
   logic [31:0] pwd, prd;
   logic [7:0]  dat, r;
   int          n_fail, checked, k;
   localparam logic [31:0] HDR = 32'h0000_1230;
   // transmit lines feed the receiver only in loopback
   acrp_top #(.FIFO_CELLS(4), .ALPHA(7), .DELTA(6)) dut (
      .CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
      .PREADY_O(prdy), .PSLVERR_O(perr), .PHY_CLK_I(phy_clk),
      .PHY_DATA_I(phy_d), .PHY_FRAME_I(phy_f), .TX_CLK_I(tx_clk),
      .TX_DATA_I(tx_d), .TX_FRAME_I(tx_f), .LOOP_SYSCLK_SEL_I(lsel),
      .ATM_RD_I(rd), .ATM_VALID_O(vld), .ATM_SOC_O(soc), .ATM_DATA_O(dat),
      .IRQ_O(irq));
   acrp_atm_model rdr (.clk_i(clk), .en_i(en), .valid_i(vld), .data_i(dat), .soc_i(soc),
                       .rd_o(rd));
   // 50 MHz system clock
   always #10 clk = ~clk;
   // ************************************
   // tasks
   // ************************************
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      checked++;
      if (g !== x) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // apb transfer; ready, data and error are taken at the rising edge that sees ready
   task automatic apb(input logic w, input logic [6:0] i, input logic [7:0] d,
                      output logic [7:0] q, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pw <= w;
      pa <= {i, 2'b00};
      pwd <= {24'h00_0000, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      if (n >= 50) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, prdy, 1'b1);
      end
      q = prd[7:0];
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rchk(input logic [6:0] i, input logic [7:0] x);
      apb(1'b0, i, 8'h00, r, e);
      chk(r, x);
   endtask
   task automatic wr(input logic [6:0] i, input logic [7:0] d);
      apb(1'b1, i, d, r, e);
   endtask
   // header check byte with the coset added back
   function automatic logic [7:0] hec(input logic [31:0] h);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
      return c ^ 8'h55;
   endfunction
   // msb first, frame pulse on each first bit, data set while clock low;
   // in loopback each bit stands 2*hp cycles so one divided tick lands in it
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         if (lp) begin
            lsel <= 1'b1;
            tx_d <= b[i];
            tx_f <= (i == 7);
         end else begin
            phy_clk <= 1'b0;
            phy_d <= b[i];
            phy_f <= (i == 7);
         end
         repeat (hp) @(posedge clk);
         if (!lp) begin
            phy_clk <= 1'b1;
         end
         repeat (hp) @(posedge clk);
      end
   endtask
   // let the reader take every stored byte
   task automatic drain();
      en <= 1'b1;
      k = 0;
      @(posedge clk);
      while (vld !== 1'b0 && k < 1000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 1000) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, vld, 1'b0);
      end
   endtask
   task automatic send_cell(input logic [31:0] h, input logic [7:0] p);
      for (int i = 3; i >= 0; i--) send_byte(h[8*i+:8]);
      send_byte(hec(h));
      repeat (48) send_byte(p);
      lsel <= 1'b0;
      repeat (20) @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ************************************
   // sequence and watchdog
   // ************************************
   initial begin
      // about 25000 cycles are needed; over twice that is a hang
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   initial begin
      {clk, rst_b, psel, pen, pw, phy_clk, phy_d, phy_f, en} = 9'h000;
      {pa, pwd, n_fail, checked} = '0;
      {tx_clk, tx_d, tx_f, lsel, lp} = 5'h00;
      hp = 2;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rchk(7'h68, 8'h04);
      rchk(7'h69, 8'h01);
      rchk(7'h6A, 8'h00);
      apb(1'b0, 7'h10, 8'h00, r, e);
      chk({e, r}, 9'h100);
      wr(7'h6A, 8'h1C);
      rchk(7'h6A, 8'h1C);
      for (k = 0; k < 7; k++) send_cell(HDR, 8'h99);
      chk(irq, 1'b1);
      rchk(7'h68, 8'h22);
      rchk(7'h68, 8'h20);
      chk(irq, 1'b0);
      wr(7'h62, 8'h00);
      wr(7'h62, 8'h00);
      // flush anything stored while sync was being gained
      en <= 1'b1;
      repeat (200) @(posedge clk);
      en <= 1'b0;
      @(posedge clk);
      rdr.q.delete();
      rdr.n_soc = 0;
      for (k = 0; k < 5; k++) send_cell(HDR, 8'hA0 + k[7:0]);
      rchk(7'h67, 8'h00);
      chk(irq, 1'b1);
      rchk(7'h68, 8'h21);
      wr(7'h62, 8'h00);
      rchk(7'h66, 8'h00);
      rchk(7'h67, 8'h05);
      drain();
      chk(16'(rdr.q.size()), 16'd208);
      chk({rdr.q[2], rdr.q[3]}, HDR[15:0]);
      chk(rdr.q[4], 8'hA0);
      chk(rdr.q[160], 8'hA3);
      // loopback: transmit lines and the divided system clock feed the receiver
      wr(7'h6A, 8'h1D);
      lp = 1'b1;
      hp = 4;
      send_cell(HDR, 8'h5C);
      drain();
      chk(16'(rdr.q.size()), 16'd260);
      chk(rdr.q[212], 8'h5C);
      chk(16'(rdr.n_soc), 16'd5);
      wr(7'h62, 8'h00);
      rchk(7'h67, 8'h01);
      end_of_test();
   end
endmodule
